// [design/host_port_pkg.sv]
/*
 * Shared constants and carriers for the host port strap configuration block.
 * Assumes a single 100 MHz clock and AXI4-Lite register access with 32-bit data.
 */
package host_port_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SQE_WINDOW_NS = 2000;
	localparam int SQE_WINDOW_CYC = (SQE_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 :
		SQE_WINDOW_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// host address map
	// ----------------------------------------------------------------
	localparam logic [9:0] IO_BASE_FIRST = 10'h300;
	localparam logic [9:0] IO_BASE_STEP = 10'h010;
	localparam logic [9:0] IO_HALF_OFFSET = 10'h008;
	localparam logic [9:0] IO_BASE_DEFAULT = 10'h310;
	localparam int IO_BLOCK_BITS = 3;
	localparam int WIN_SMALL_BITS = 14;
	localparam int WIN_LARGE_BITS = 17;
	localparam logic [5:0] WIN_BASE_DEFAULT = 6'h28;

	// ----------------------------------------------------------------
	// register offsets and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_WINDOW_BASE = 8'h00;
	localparam logic [7:0] REG_STRAP_STATUS = 8'h04;
	localparam logic [7:0] REG_EVENT_STATUS = 8'h08;
	localparam int FLD_IO_BASE_LSB = 0;
	localparam int FLD_WIN_LARGE = 10;
	localparam int FLD_IRQ_LEVEL_LSB = 12;
	localparam int FLD_LEGACY = 16;
	localparam int FLD_PARITY_EN = 17;
	localparam int FLD_IRQ_NONE = 18;
	localparam int FLD_IO_NONE = 19;
	localparam int EVT_PARITY = 0;
	localparam int EVT_SQE_FAIL = 1;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] io_base_select_strap;
		logic io_half_select_strap;
		logic irq_level7_strap;
		logic irq_level6_strap;
		logic irq_level5_strap;
		logic irq_level4_strap;
		logic irq_level3_strap;
		logic irq_level2_strap;
		logic xcvr_legacy_mode_strap;
		logic window_size_strap_a;
		logic window_size_strap_b;
		logic window_size_strap_c;
		logic window_size_strap_d;
		logic window_size_strap_e;
		logic window_size_strap_f;
		logic parity_irq_strap;
	} strap_bundle_t;

	typedef struct packed {
		logic [9:0] io_base;
		logic io_none;
		logic win_large;
		logic [5:0] irq_sel;
		logic [2:0] irq_level;
		logic irq_none;
		logic legacy_mode;
		logic parity_irq_en;
	} strap_cfg_t;

	localparam strap_cfg_t CFG_FACTORY = '{
		io_base: IO_BASE_DEFAULT, io_none: 1'b0, win_large: 1'b0,
		irq_sel: 6'b00_0001, irq_level: 3'h2, irq_none: 1'b0,
		legacy_mode: 1'b1, parity_irq_en: 1'b1};

	typedef enum logic {
		SQE_IDLE = 1'b0,
		SQE_WAIT = 1'b1
	} sqe_state_t;

endpackage : host_port_pkg

// [design/strap_decode.sv]
/*
 * Combinational decode of the raw strap levels into a configuration word.
 * Assumes strap inputs are static levels, 1 meaning the strap is fitted
 * (window size straps: 1 means linked for the large window).
 */
`timescale 1ns/10ps
`default_nettype none

module strap_decode
	import host_port_pkg::*;
(
	// raw straps
	input wire strap_bundle_t straps,
	// decoded configuration
	output strap_cfg_t cfg
);

	wire [5:0] irq_straps = {straps.irq_level7_strap, straps.irq_level6_strap,
		straps.irq_level5_strap, straps.irq_level4_strap,
		straps.irq_level3_strap, straps.irq_level2_strap};
	wire [5:0] size_straps = {straps.window_size_strap_a, straps.window_size_strap_b,
		straps.window_size_strap_c, straps.window_size_strap_d,
		straps.window_size_strap_e, straps.window_size_strap_f};

	logic [2:0] base_idx;
	logic base_found;
	logic [2:0] irq_idx;
	logic irq_found;

	// lowest fitted strap wins, so only one base and one line are ever chosen
	always_comb
	begin
		base_idx = 3'd0;
		base_found = 1'b0;
		irq_idx = 3'd0;
		irq_found = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			if (straps.io_base_select_strap[i])
			begin
				base_idx = 3'(i);
				base_found = 1'b1;
			end
		end
		for (int i = 5; i >= 0; i--)
		begin
			if (irq_straps[i])
			begin
				irq_idx = 3'(i);
				irq_found = 1'b1;
			end
		end
	end

	assign cfg.io_base = IO_BASE_FIRST + 10'(base_idx * IO_BASE_STEP) +
		(straps.io_half_select_strap ? IO_HALF_OFFSET : 10'h000);
	assign cfg.io_none = !base_found;
	assign cfg.win_large = &size_straps;
	assign cfg.irq_sel = irq_found ? 6'(6'b00_0001 << irq_idx) : 6'b00_0000;
	assign cfg.irq_level = irq_idx + 3'd2;
	assign cfg.irq_none = !irq_found;
	assign cfg.legacy_mode = straps.xcvr_legacy_mode_strap;
	assign cfg.parity_irq_en = straps.parity_irq_strap;

endmodule : strap_decode

`default_nettype wire

// [design/host_port_strap_config.sv]
/*
 * Host attachment configuration: I/O block decode, memory window decode,
 * interrupt line routing, heartbeat check after transmit, AXI4-Lite registers.
 * Assumes host bus signals and straps are synchronous to ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module host_port_strap_config
	import host_port_pkg::*;
#(
	parameter int SQE_CYCLES = SQE_WINDOW_CYC
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// straps
	input wire strap_bundle_t straps,
	// host I/O and memory decode
	input wire logic [9:0] host_io_addr,
	input wire logic host_io_valid,
	output logic io_block_hit,
	output logic [2:0] io_reg_index,
	input wire logic [19:0] host_mem_addr,
	input wire logic host_mem_valid,
	output logic mem_window_hit,
	output logic [16:0] mem_window_offset,
	// interrupt sources and host request lines 2..7
	input wire logic board_irq,
	input wire logic parity_error,
	output logic [5:0] host_irq_out,
	output logic [5:0] host_irq_oe,
	// transceiver heartbeat
	input wire logic tx_done,
	input wire logic sqe_seen,
	output logic sqe_check_en
);

	// ----------------------------------------------------------------
	// strap capture after reset release
	// ----------------------------------------------------------------
	strap_cfg_t decoded;
	strap_cfg_t cfg_q;
	logic captured_q;

	strap_decode u_strap_decode (
		.straps(straps),
		.cfg(decoded)
	);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_q <= CFG_FACTORY;
			captured_q <= 1'b0;
		end
		else if (!captured_q)
		begin
			cfg_q <= decoded;
			captured_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// host address decode
	// ----------------------------------------------------------------
	logic [5:0] win_base_q;
	wire io_match = host_io_valid && !cfg_q.io_none &&
		(host_io_addr[9:IO_BLOCK_BITS] == cfg_q.io_base[9:IO_BLOCK_BITS]);
	wire small_match = host_mem_addr[19:WIN_SMALL_BITS] == win_base_q;
	wire large_match = host_mem_addr[19:WIN_LARGE_BITS] == win_base_q[5:3];
	wire mem_match = host_mem_valid && (cfg_q.win_large ? large_match : small_match);
	wire [16:0] mem_off = cfg_q.win_large ? host_mem_addr[16:0] :
		{3'b000, host_mem_addr[WIN_SMALL_BITS-1:0]};

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			io_block_hit <= 1'b0;
			io_reg_index <= 3'h0;
			mem_window_hit <= 1'b0;
			mem_window_offset <= 17'h0_0000;
		end
		else
		begin
			io_block_hit <= io_match;
			io_reg_index <= host_io_addr[IO_BLOCK_BITS-1:0];
			mem_window_hit <= mem_match;
			mem_window_offset <= mem_off;
		end
	end

	// ----------------------------------------------------------------
	// heartbeat check after transmit
	// ----------------------------------------------------------------
	sqe_state_t sqe_state_q;
	logic [15:0] sqe_cnt_q;
	logic sqe_fail_ev;

	assign sqe_check_en = !cfg_q.legacy_mode;
	assign sqe_fail_ev = (sqe_state_q == SQE_WAIT) && !sqe_seen && (sqe_cnt_q == 16'h0001);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sqe_state_q <= SQE_IDLE;
			sqe_cnt_q <= 16'h0000;
		end
		else
		begin
			unique case (sqe_state_q)
				SQE_IDLE:
				begin
					if (tx_done && sqe_check_en)
					begin
						sqe_state_q <= SQE_WAIT;
						sqe_cnt_q <= 16'(SQE_CYCLES);
					end
				end
				SQE_WAIT:
				begin
					if (sqe_seen || sqe_cnt_q == 16'h0001)
						sqe_state_q <= SQE_IDLE;
					sqe_cnt_q <= sqe_cnt_q - 16'h0001;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [1:0] evt_q;

	wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	wire wr_base = do_write && aw_addr_q == REG_WINDOW_BASE;
	wire wr_evt = do_write && aw_addr_q == REG_EVENT_STATUS;
	wire wr_known = wr_base || wr_evt || aw_addr_q == REG_STRAP_STATUS;
	wire [1:0] evt_clr = (wr_evt && w_strb_q[0]) ? w_data_q[1:0] : 2'b00;
	wire [1:0] evt_set = {sqe_fail_ev, parity_error};
	wire [31:0] strap_word = (32'(cfg_q.io_base) << FLD_IO_BASE_LSB) |
		(32'(cfg_q.win_large) << FLD_WIN_LARGE) |
		(32'(cfg_q.irq_level) << FLD_IRQ_LEVEL_LSB) |
		(32'(cfg_q.legacy_mode) << FLD_LEGACY) |
		(32'(cfg_q.parity_irq_en) << FLD_PARITY_EN) |
		(32'(cfg_q.irq_none) << FLD_IRQ_NONE) |
		(32'(cfg_q.io_none) << FLD_IO_NONE);
	wire rd_base = s_axi_araddr == REG_WINDOW_BASE;
	wire rd_strap = s_axi_araddr == REG_STRAP_STATUS;
	wire rd_evt = s_axi_araddr == REG_EVENT_STATUS;
	wire [31:0] rd_word = rd_base ? {26'h0, win_base_q} :
		rd_strap ? strap_word : rd_evt ? {30'h0, evt_q} : 32'h0000_0000;

	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready = !w_held_q;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (rd_base || rd_strap || rd_evt) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// window base and sticky events; a new event beats its own clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			win_base_q <= WIN_BASE_DEFAULT;
			evt_q <= 2'b00;
		end
		else
		begin
			if (wr_base && w_strb_q[0])
				win_base_q <= w_data_q[5:0];
			evt_q <= (evt_q & ~evt_clr) | evt_set;
		end
	end

	// ----------------------------------------------------------------
	// host interrupt routing
	// ----------------------------------------------------------------
	wire irq_request = board_irq || (cfg_q.parity_irq_en && evt_q[EVT_PARITY]);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_irq_out <= 6'b00_0000;
			host_irq_oe <= 6'b00_0000;
		end
		else
		begin
			host_irq_oe <= cfg_q.irq_sel;
			host_irq_out <= irq_request ? cfg_q.irq_sel : 6'b00_0000;
		end
	end

endmodule : host_port_strap_config

`default_nettype wire

// [dv/host_port_monitor.sv]
/* checker for host_port_strap_config.
   bound into the design; straps change only while reset is held */
`timescale 1ns/10ps
`default_nettype none
module host_port_monitor
	import host_port_pkg::*;
#(
	parameter int SQE_CYCLES = SQE_WINDOW_CYC
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// observed ports
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire strap_bundle_t straps,
	input wire logic [9:0] host_io_addr,
	input wire logic host_io_valid,
	input wire logic io_block_hit,
	input wire logic [2:0] io_reg_index,
	input wire logic [19:0] host_mem_addr,
	input wire logic mem_window_hit,
	input wire logic [16:0] mem_window_offset,
	input wire logic board_irq,
	input wire logic parity_error,
	input wire logic [5:0] host_irq_out,
	input wire logic [5:0] host_irq_oe,
	input wire logic sqe_check_en
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	wire logic [5:0] irq_s = {straps.irq_level7_strap, straps.irq_level6_strap,
		straps.irq_level5_strap, straps.irq_level4_strap, straps.irq_level3_strap,
		straps.irq_level2_strap};
	wire logic big = &{straps.window_size_strap_a, straps.window_size_strap_b,
		straps.window_size_strap_c, straps.window_size_strap_d,
		straps.window_size_strap_e, straps.window_size_strap_f};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_par;
		parity_error && straps.parity_irq_strap && |host_irq_oe;
	endsequence
	property p_io_idx;
		io_block_hit |-> $past(host_io_valid) && io_reg_index == $past(host_io_addr[2:0]);
	endproperty
	a_io_idx: assert property (p_io_idx) else $error("io index wrong");
	property p_io_rng;
		io_block_hit |-> $past(host_io_addr[9:7]) == 3'h6;
	endproperty
	a_io_rng: assert property (p_io_rng) else $error("io block out of range");
	property p_win;
		$past(rst_n, 2) && mem_window_hit && !big |->
			mem_window_offset == {3'h0, $past(host_mem_addr[13:0])};
	endproperty
	a_win: assert property (p_win) else $error("small window offset wrong");
	property p_irq_sel;
		$past(rst_n, 2) && $past(rst_n) |-> host_irq_oe == (irq_s & (~irq_s + 6'h01));
	endproperty
	a_irq_sel: assert property (p_irq_sel) else $error("irq enable wrong");
	property p_irq_drv;
		$past(board_irq) && |host_irq_oe |-> |(host_irq_out & host_irq_oe);
	endproperty
	a_irq_drv: assert property (p_irq_drv) else $error("irq not driven");
	property p_sqe_en;
		$past(rst_n, 2) && $past(rst_n) |-> sqe_check_en == !straps.xcvr_legacy_mode_strap;
	endproperty
	a_sqe_en: assert property (p_sqe_en) else $error("heartbeat enable wrong");
	property p_par;
		s_par |-> ##[1:2] |(host_irq_out & host_irq_oe);
	endproperty
	a_par: assert property (p_par) else $error("parity irq missing");
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
endmodule : host_port_monitor
bind host_port_strap_config host_port_monitor #(.SQE_CYCLES(SQE_CYCLES)) mon_u (.*);
`default_nettype wire

// [dv/host_bus_model.sv]
/* host side of the request lines.
   resolves each line from the board's drive and enable */
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
(
	// clock
	input wire logic ref_clk,
	// board drive
	input wire logic [5:0] host_irq_out,
	input wire logic [5:0] host_irq_oe,
	// line levels seen by the host
	output logic [5:0] irq_line
);
	// ----------------------------------------------------------------
	// undriven lines wander so a stale level never passes for a drive
	// ----------------------------------------------------------------
	logic [5:0] float_q = 6'h15;
	always_ff @(posedge ref_clk) float_q <= ~float_q;
	assign irq_line = (host_irq_out & host_irq_oe) | (float_q & ~host_irq_oe);
endmodule : host_bus_model
`default_nettype wire

// [dv/test_host_port_strap_config.sv]
/* self-checking bench for host_port_strap_config.
   assumes host_bus_model and the bound monitor */
`timescale 1ns/10ps
`default_nettype none
module test_host_port_strap_config
	import host_port_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and tasks
	// ----------------------------------------------------------------
	localparam int SQE_CYCLES = 4;
	logic ref_clk = 1'b0, rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_done = 1'b0, sqe_seen = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
	strap_bundle_t straps = '0;
	logic [9:0] host_io_addr = 10'h000;
	logic [19:0] host_mem_addr = 20'h0_0000;
	logic host_io_valid = 1'b0, host_mem_valid = 1'b0, board_irq = 1'b0, parity_error = 1'b0;
	logic io_block_hit, mem_window_hit, sqe_check_en;
	logic [2:0] io_reg_index;
	logic [16:0] mem_window_offset;
	logic [5:0] host_irq_out, host_irq_oe, irq_line;
	int error_cnt = 0, comparisons = 0;
	host_port_strap_config #(.SQE_CYCLES(SQE_CYCLES)) dut_u (.*);
	host_bus_model bus_u (.*);
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic lim(input int n);
		if (n >= 99)
		begin
			error_cnt++;
			give_verdict;
		end
	endtask : lim
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 99; n++)
		begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		lim(n);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 99; n++)
		begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		lim(n);
	endtask : axi_rd
	task automatic do_reset(input strap_bundle_t s);
		rst_n <= 1'b0;
		straps <= s;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask : do_reset
	function automatic strap_bundle_t fac(input logic legacy);
		strap_bundle_t s;
		s = '0;
		s.io_base_select_strap = 8'h02;
		s.irq_level2_strap = 1'b1;
		s.xcvr_legacy_mode_strap = legacy;
		s.parity_irq_strap = 1'b1;
		return s;
	endfunction : fac
	task automatic probe_io(input logic [9:0] a, input logic e);
		host_io_addr <= a;
		host_io_valid <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(io_block_hit, e);
		if (e)
			chk(io_reg_index, a[2:0]);
		host_io_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : probe_io
	task automatic probe_mem(input logic [19:0] a, input logic e, input logic [16:0] o);
		host_mem_addr <= a;
		host_mem_valid <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(mem_window_hit, e);
		if (e)
			chk(mem_window_offset, o);
		host_mem_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : probe_mem
	task automatic t_factory;
		axi_rd(REG_STRAP_STATUS, rd_d, rd_r);
		chk(rd_d, 32'h0003_2310);
		axi_rd(REG_WINDOW_BASE, rd_d, rd_r);
		chk(rd_d, 32'h0000_0028);
		axi_rd(8'h0c, rd_d, rd_r);
		chk(rd_r, RESP_SLVERR);
		axi_wr(REG_WINDOW_BASE, 32'h0000_0031, rd_r);
		chk(rd_r, RESP_OKAY);
		probe_mem(20'hc_4000, 1'b1, 17'h0_0000);
		probe_mem(20'ha_0000, 1'b0, 17'h0_0000);
		probe_mem(20'hc_7fff, 1'b1, 17'h0_3fff);
		probe_mem(20'hc_8000, 1'b0, 17'h0_0000);
		$display("t_factory done");
	endtask : t_factory
	task automatic t_irq;
		board_irq <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(irq_line[0], 1'b1);
		chk(host_irq_oe, 6'h01);
		board_irq <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(irq_line[0], 1'b0);
		parity_error <= 1'b1;
		@(posedge ref_clk);
		parity_error <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(irq_line[0], 1'b1);
		axi_rd(REG_EVENT_STATUS, rd_d, rd_r);
		chk(rd_d[0], 1'b1);
		axi_wr(REG_EVENT_STATUS, 32'h0000_0001, rd_r);
		repeat (2) @(posedge ref_clk);
		chk(irq_line[0], 1'b0);
		$display("t_irq done");
	endtask : t_irq
	task automatic pulse_tx(input logic hb, input logic e);
		tx_done <= 1'b1;
		@(posedge ref_clk);
		tx_done <= 1'b0;
		sqe_seen <= hb;
		@(posedge ref_clk);
		sqe_seen <= 1'b0;
		repeat (SQE_CYCLES + 4) @(posedge ref_clk);
		axi_rd(REG_EVENT_STATUS, rd_d, rd_r);
		chk(rd_d[1], e);
		axi_wr(REG_EVENT_STATUS, 32'h0000_0002, rd_r);
	endtask : pulse_tx
	task automatic t_sqe;
		do_reset(fac(1'b0));
		pulse_tx(1'b1, 1'b0);
		pulse_tx(1'b0, 1'b1);
		do_reset(fac(1'b1));
		pulse_tx(1'b0, 1'b0);
		$display("t_sqe done");
	endtask : t_sqe
	task automatic t_map;
		strap_bundle_t s;
		logic [9:0] b;
		logic [19:0] top;
		for (int i = 0; i < 16; i++)
		begin
			s = '0;
			s.io_base_select_strap = 8'h01 << (i / 2);
			s.io_half_select_strap = i[0];
			{s.irq_level7_strap, s.irq_level6_strap, s.irq_level5_strap, s.irq_level4_strap,
				s.irq_level3_strap, s.irq_level2_strap} = 6'h01 << (i % 6);
			s.xcvr_legacy_mode_strap = i[0];
			{s.window_size_strap_a, s.window_size_strap_b, s.window_size_strap_c,
				s.window_size_strap_d, s.window_size_strap_e, s.window_size_strap_f} = {6{i[1]}};
			s.parity_irq_strap = i[2];
			do_reset(s);
			b = 10'h300 + 10'(i * 8);
			probe_io(b, 1'b1);
			probe_io(b + 10'h007, 1'b1);
			probe_io(b + 10'h008, 1'b0);
			probe_io(b - 10'h001, 1'b0);
			chk(host_irq_oe, 6'h01 << (i % 6));
			chk(sqe_check_en, !i[0]);
			axi_rd(REG_STRAP_STATUS, rd_d, rd_r);
			chk(rd_d, {14'h0, i[2], i[0], 1'b0, 3'(2 + i % 6), 1'b0, i[1], b});
			top = i[1] ? 20'hb_ffff : 20'ha_3fff;
			probe_mem(top, 1'b1, i[1] ? 17'h1_ffff : 17'h0_3fff);
			probe_mem(top + 20'h0_0001, 1'b0, 17'h0_0000);
		end
		$display("t_map done");
	endtask : t_map
	task automatic t_none;
		strap_bundle_t s;
		s = '0;
		do_reset(s);
		probe_io(10'h300, 1'b0);
		probe_io(10'h317, 1'b0);
		chk(host_irq_oe, 6'h00);
		axi_rd(REG_STRAP_STATUS, rd_d, rd_r);
		chk({rd_d[FLD_IO_NONE], rd_d[FLD_IRQ_NONE]}, 2'b11);
		board_irq <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(host_irq_out, 6'h00);
		board_irq <= 1'b0;
		s.io_base_select_strap = 8'h84;
		s.irq_level4_strap = 1'b1;
		s.irq_level6_strap = 1'b1;
		do_reset(s);
		probe_io(10'h320, 1'b1);
		probe_io(10'h370, 1'b0);
		chk(host_irq_oe, 6'h04);
		parity_error <= 1'b1;
		@(posedge ref_clk);
		parity_error <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(host_irq_out, 6'h00);
		axi_rd(REG_EVENT_STATUS, rd_d, rd_r);
		chk(rd_d[EVT_PARITY], 1'b1);
		axi_wr(REG_EVENT_STATUS, 32'h0000_0001, rd_r);
		chk(rd_r, RESP_OKAY);
		axi_wr(8'h0c, 32'h0000_0000, rd_r);
		chk(rd_r, RESP_SLVERR);
		$display("t_none done");
	endtask : t_none
	initial
	begin
		do_reset(fac(1'b1));
		t_factory;
		t_irq;
		t_sqe;
		t_map;
		t_none;
		give_verdict;
	end
endmodule : test_host_port_strap_config
`default_nettype wire
